// [design/wdt_regs.sv]
// Watchdog down-counter with AXI4-Lite register bank
`timescale 1ns/10ps
module wdt_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // Write address channel
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [ADDR_W-1:0] AWADDR,
    // Write data channel
    input  wire logic              WVALID,
    output logic                   WREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    // Write response channel
    output logic                   BVALID,
    input  wire logic              BREADY,
    output logic [1:0]             BRESP,
    // Read address channel
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    // Read data channel
    output logic                   RVALID,
    input  wire logic              RREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    // Watchdog pins and event interrupt
    output logic                   INTERRUPT_OUTPUT,
    output logic                   RESET_OUTPUT,
    output logic                   EVENT_IRQ
);

    // Refuse address widths that cannot reach the top register
    if (ADDR_W < 12) begin : g_addr_chk
        $error("ADDR_W must be at least 12");
    end

    // Byte-lane merge of write data into an old value
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0]       load_reg;
    logic [31:0]       count_reg;
    logic [31:0]       count_next;
    wdt_pkg::ctrl_t    ctrl_reg;
    wdt_pkg::tout_t    tout_reg;
    wdt_pkg::ev_t      evst_reg;
    wdt_pkg::ev_t      evst_next;
    wdt_pkg::ev_t      evmsk_reg;
    logic              raw_reg;
    logic              halt_reg;
    logic              locked_reg;
    logic              tmode_reg;
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              int_out_reg;
    logic              rst_out_reg;
    logic              irq_reg;

    // Bus handshakes and write launch
    wire aw_hs = AWVALID & AWREADY;
    wire w_hs  = WVALID & WREADY;
    wire ar_hs = ARVALID & ARREADY;
    wire do_wr = aw_full_reg & w_full_reg & ~BVALID;
    wire aw_full_next = aw_hs | (aw_full_reg & ~do_wr);
    wire w_full_next  = w_hs | (w_full_reg & ~do_wr);
    wire bvalid_next  = do_wr | (BVALID & ~BREADY);
    wire rvalid_next  = ar_hs | (RVALID & ~RREADY);

    // Write address decode
    wire [11:0] wa   = {awaddr_reg[11:2], 2'h0};
    wire        w_hi = (awaddr_reg >> 12) == '0;
    wire w_load  = w_hi && wa == wdt_pkg::LOAD_OFS;
    wire w_ctrl  = w_hi && wa == wdt_pkg::CTRL_OFS;
    wire w_clr   = w_hi && wa == wdt_pkg::ICLR_OFS;
    wire w_evst  = w_hi && wa == wdt_pkg::EVST_OFS;
    wire w_evmsk = w_hi && wa == wdt_pkg::EVMSK_OFS;
    wire w_key   = w_hi && wa == wdt_pkg::KEY_OFS;
    wire w_tctl  = w_hi && wa == wdt_pkg::TCTL_OFS;
    wire w_tout  = w_hi && wa == wdt_pkg::TOUT_OFS;
    wire w_ro    = w_hi && (wa == wdt_pkg::COUNT_OFS || wa == wdt_pkg::RIS_OFS
                            || wa == wdt_pkg::MIS_OFS);
    wire w_map   = w_load | w_ctrl | w_clr | w_evst | w_evmsk | w_key | w_tctl
                   | w_tout | w_ro;

    // Gate writes with the lock
    // Locked writes ignored, except to the key register
    wire unl      = ~locked_reg;
    wire wr_load  = do_wr & w_load & unl;
    wire wr_ctrl  = do_wr & w_ctrl & unl & wstrb_reg[0];
    wire wr_clr   = do_wr & w_clr & unl;
    wire wr_evst  = do_wr & w_evst & unl & wstrb_reg[0];
    wire wr_evmsk = do_wr & w_evmsk & unl & wstrb_reg[0];
    wire wr_tctl  = do_wr & w_tctl & unl & wstrb_reg[0];
    wire wr_tout  = do_wr & w_tout & unl & wstrb_reg[0];
    wire wr_key   = do_wr & w_key;
    wire wr_cnt   = wr_load | wr_clr;
    wire [31:0] wv_load = merge(load_reg, wdata_reg, wstrb_reg);
    wire [31:0] wv      = merge(32'h0, wdata_reg, wstrb_reg);

    // Counter run conditions and zero events
    // Interrupt enable runs counter
    wire run      = ctrl_reg.int_en & ~halt_reg;
    wire zero_evt = run & (count_reg == 32'h0);
    wire raw_hit  = zero_evt & ~raw_reg;
    wire rst_hit  = zero_evt & raw_reg & ctrl_reg.res_en;
    wire masked   = raw_reg & ctrl_reg.int_en;
    // Reset pin gated by enable
    // The request stays sticky, but the pin drops if software clears the enable
    wire rst_req  = halt_reg & ctrl_reg.res_en;

    // Next count value, software loads first
    // Reload write restarts
    assign count_next = wr_load  ? wv_load :
                        wr_clr   ? load_reg :
                        rst_hit  ? count_reg :
                        zero_evt ? load_reg :
                        run      ? count_reg - 32'h1 : count_reg;

    // Event flags, a new event wins over a clearing write
    wire [1:0] ev_clr = wr_evst ? wv[wdt_pkg::EVT_HI:wdt_pkg::EVT_LO] : 2'h0;
    assign evst_next = wdt_pkg::ev_t'({rst_hit, raw_hit} | (evst_reg & ~ev_clr));

    // Counter, reload value and watchdog state
    always_ff @(posedge CLK) begin
        if (RST) begin
            load_reg  <= wdt_pkg::LOAD_RST;
            count_reg <= wdt_pkg::COUNT_RST;
            raw_reg   <= 1'h0;
            halt_reg  <= 1'h0;
            evst_reg  <= '0;
        end else begin
            if (wr_load) begin
                load_reg <= wv_load;
            end
            count_reg <= count_next;
            raw_reg   <= raw_hit | (raw_reg & ~wr_clr);
            halt_reg  <= halt_reg | rst_hit;
            evst_reg  <= evst_next;
        end
    end

    // Software control registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_reg  <= '0;
            tout_reg  <= '0;
            evmsk_reg <= '0;
            tmode_reg <= 1'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wdt_pkg::ctrl_t'(wv[wdt_pkg::RESET_OUTPUT_ENABLE_BIT:wdt_pkg::INTERRUPT_ENABLE_BIT]);
            end
            if (wr_tout) begin
                tout_reg <= wdt_pkg::tout_t'(wv[wdt_pkg::TINT_BIT:wdt_pkg::TRST_BIT]);
            end
            if (wr_evmsk) begin
                evmsk_reg <= wdt_pkg::ev_t'(wv[wdt_pkg::EVT_HI:wdt_pkg::EVT_LO]);
            end
            if (wr_tctl) begin
                tmode_reg <= wv[wdt_pkg::TMODE_BIT];
            end
        end
    end

    // Write key lock
    // Key unlocks, else locks
    always_ff @(posedge CLK) begin
        if (RST) begin
            locked_reg <= wdt_pkg::LOCK_RST;
        end else if (wr_key) begin
            locked_reg <= (wv != wdt_pkg::UNLOCK_KEY);
        end
    end

    // Watchdog pins selected by test mode, event interrupt from masked event flags
    // Test interrupt value
    always_ff @(posedge CLK) begin
        if (RST) begin
            int_out_reg <= 1'h0;
            rst_out_reg <= 1'h0;
            irq_reg     <= 1'h0;
        end else begin
            int_out_reg <= tmode_reg ? tout_reg.tint : masked;
            rst_out_reg <= tmode_reg ? tout_reg.trst : rst_req;
            irq_reg     <= |(evst_reg & evmsk_reg);
        end
    end

    // Write channels: hold address and data until both are present
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_full_reg <= 1'h0;
            w_full_reg  <= 1'h0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            if (aw_hs) begin
                awaddr_reg <= AWADDR;
            end
            if (w_hs) begin
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end
        end
    end

    // Write handshake outputs and response
    always_ff @(posedge CLK) begin
        if (RST) begin
            AWREADY <= 1'h0;
            WREADY  <= 1'h0;
            BVALID  <= 1'h0;
            BRESP   <= wdt_pkg::RESP_OKAY;
        end else begin
            AWREADY <= ~aw_full_next;
            WREADY  <= ~w_full_next;
            BVALID  <= bvalid_next;
            if (do_wr) begin
                BRESP <= w_map ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            end
        end
    end

    // Read address decode and data selection
    // Live count readback
    wire [11:0] ra   = {ARADDR[11:2], 2'h0};
    wire        r_hi = (ARADDR >> 12) == '0;
    wire [31:0] r_ctrl = {30'h0, ctrl_reg};
    wire [31:0] r_tout = {30'h0, tout_reg};
    wire [31:0] r_evst = {30'h0, evst_reg};
    wire [31:0] r_evmk = {30'h0, evmsk_reg};
    wire        r_map;
    wire [31:0] r_val;
    assign r_map = r_hi && (ra == wdt_pkg::LOAD_OFS || ra == wdt_pkg::COUNT_OFS
                   || ra == wdt_pkg::CTRL_OFS || ra == wdt_pkg::ICLR_OFS
                   || ra == wdt_pkg::RIS_OFS || ra == wdt_pkg::MIS_OFS
                   || ra == wdt_pkg::EVST_OFS || ra == wdt_pkg::EVMSK_OFS
                   || ra == wdt_pkg::KEY_OFS || ra == wdt_pkg::TCTL_OFS
                   || ra == wdt_pkg::TOUT_OFS);
    assign r_val = !r_hi                     ? 32'h0 :
                   ra == wdt_pkg::LOAD_OFS   ? load_reg :
                   ra == wdt_pkg::COUNT_OFS  ? count_reg :
                   ra == wdt_pkg::CTRL_OFS   ? r_ctrl :
                   ra == wdt_pkg::RIS_OFS    ? {31'h0, raw_reg} :
                   ra == wdt_pkg::MIS_OFS    ? {31'h0, masked} :
                   ra == wdt_pkg::EVST_OFS   ? r_evst :
                   ra == wdt_pkg::EVMSK_OFS  ? r_evmk :
                   ra == wdt_pkg::KEY_OFS    ? {31'h0, locked_reg} :
                   ra == wdt_pkg::TCTL_OFS   ? {31'h0, tmode_reg} :
                   ra == wdt_pkg::TOUT_OFS   ? r_tout : 32'h0;

    // Read channel, one read in flight
    always_ff @(posedge CLK) begin
        if (RST) begin
            ARREADY <= 1'h0;
            RVALID  <= 1'h0;
            RDATA   <= 32'h0;
            RRESP   <= wdt_pkg::RESP_OKAY;
        end else begin
            ARREADY <= ~rvalid_next;
            RVALID  <= rvalid_next;
            if (ar_hs) begin
                RDATA <= r_val;
                RRESP <= r_map ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            end
        end
    end

    assign INTERRUPT_OUTPUT = int_out_reg;
    assign RESET_OUTPUT     = rst_out_reg;
    assign EVENT_IRQ        = irq_reg;

    // Checks on the counter, bank and pins
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_zero_first;
        zero_evt && !raw_reg && !wr_cnt;
    endsequence
    sequence s_pend_reset;
        zero_evt && raw_reg && ctrl_reg.res_en && !wr_cnt;
    endsequence

    load_restart_a: assert property (wr_load |=> count_reg == $past(wv_load))
        else $error("count did not restart from written reload");
    count_read_a: assert property (ar_hs && ra == wdt_pkg::COUNT_OFS
        |=> RDATA == $past(count_reg))
        else $error("count read returned wrong value");
    reset_gate_a: assert property (!ctrl_reg.res_en && !halt_reg |=> !halt_reg)
        else $error("reset request without reset enable");
    reset_pin_gate_a: assert property (!tmode_reg && !ctrl_reg.res_en
        |=> !RESET_OUTPUT)
        else $error("reset pin high without reset enable");
    run_enable_a: assert property (!ctrl_reg.int_en && !wr_cnt
        |=> count_reg == $past(count_reg))
        else $error("counter moved while disabled");
    clear_reload_a: assert property (wr_clr && !raw_hit
        |=> !raw_reg && count_reg == $past(load_reg))
        else $error("interrupt clear failed");
    masked_read_a: assert property (ar_hs && ra == wdt_pkg::MIS_OFS
        |=> RDATA == {31'h0, $past(raw_reg & ctrl_reg.int_en)})
        else $error("masked status wrong");
    lock_key_a: assert property (wr_key
        |=> locked_reg == ($past(wv) != wdt_pkg::UNLOCK_KEY))
        else $error("lock state wrong after key write");
    lock_read_a: assert property (ar_hs && ra == wdt_pkg::KEY_OFS
        |=> RDATA == {31'h0, $past(locked_reg)})
        else $error("lock read wrong");
    test_int_a: assert property (tmode_reg |=> INTERRUPT_OUTPUT == $past(tout_reg.tint))
        else $error("test interrupt value not driven");
    test_rst_a: assert property (tmode_reg ##1 tmode_reg
        |-> RESET_OUTPUT == $past(tout_reg.trst))
        else $error("test reset value not driven");
    decrement_a: assert property (run && count_reg != 32'h0 && !wr_cnt
        |=> count_reg == $past(count_reg) - 32'h1)
        else $error("counter did not decrement");
    first_zero_a: assert property (s_zero_first
        |=> raw_reg && count_reg == $past(load_reg))
        else $error("first timeout not handled");
    halt_stop_a: assert property (s_pend_reset
        |=> halt_reg ##1 (RESET_OUTPUT || tmode_reg || !$past(ctrl_reg.res_en)))
        else $error("reset request not raised");
    locked_ign_a: assert property (do_wr && locked_reg && w_ctrl
        |=> ctrl_reg == $past(ctrl_reg))
        else $error("write accepted while locked");
    normal_out_a: assert property (!tmode_reg |=> RESET_OUTPUT == $past(rst_req)
        && INTERRUPT_OUTPUT == $past(masked))
        else $error("pins do not follow watchdog state");

endmodule // wdt_regs

// [design/wdt_pkg.sv]
// Shared constants and types for the watchdog register block
package wdt_pkg;
    // Register byte offsets
    localparam logic [11:0] LOAD_OFS  = 12'h000;
    localparam logic [11:0] COUNT_OFS = 12'h004;
    localparam logic [11:0] CTRL_OFS  = 12'h008;
    localparam logic [11:0] ICLR_OFS  = 12'h00C;
    localparam logic [11:0] RIS_OFS   = 12'h010;
    localparam logic [11:0] MIS_OFS   = 12'h014;
    localparam logic [11:0] EVST_OFS  = 12'h018;
    localparam logic [11:0] EVMSK_OFS = 12'h01C;
    localparam logic [11:0] KEY_OFS   = 12'hC00;
    localparam logic [11:0] TCTL_OFS  = 12'hF00;
    localparam logic [11:0] TOUT_OFS  = 12'hF04;
    // Values after reset
    localparam logic [31:0] LOAD_RST  = 32'h0FFFFFFF;
    localparam logic [31:0] COUNT_RST = 32'h0FFFFFFF;
    localparam logic        LOCK_RST  = 1'h0;
    // Write key that opens the register bank
    localparam logic [31:0] UNLOCK_KEY = 32'h1ACCE551;
    // Field positions
    localparam int INTERRUPT_ENABLE_BIT = 0;
    localparam int RESET_OUTPUT_ENABLE_BIT = 1;
    localparam int TMODE_BIT = 0;
    localparam int TRST_BIT  = 0;
    localparam int TINT_BIT  = 1;
    localparam int EVT_LO    = 0;
    localparam int EVT_HI    = 1;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control field, bit 1 reset enable, bit 0 interrupt enable
    typedef struct packed {
        logic res_en;
        logic int_en;
    } ctrl_t;

    // Test output field, bit 1 interrupt value, bit 0 reset value
    typedef struct packed {
        logic tint;
        logic trst;
    } tout_t;

    // Event bits, bit 1 reset request raised, bit 0 first timeout
    typedef struct packed {
        logic reset_evt;
        logic timeout_evt;
    } ev_t;
endpackage

// [dv/tb_top.sv]
// Self-checking bench for the watchdog register block over AXI4-Lite
`timescale 1ns/10ps
module tb_top;
    // Clock, reset and bus signals
    logic        CLK;
    logic        RST;
    logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic        ARVALID, ARREADY, RVALID, RREADY;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP;
    logic        INTERRUPT_OUTPUT, RESET_OUTPUT, EVENT_IRQ;
    // Bench bookkeeping
    int          errors;
    int          checks_done;
    int          cycles;
    logic [31:0] last_data;
    logic [1:0]  last_resp;
    localparam int CYCLE_LIMIT = 20000;

    wdt_regs dut (
        .CLK(CLK), .RST(RST),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
        .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
        .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
        .INTERRUPT_OUTPUT(INTERRUPT_OUTPUT), .RESET_OUTPUT(RESET_OUTPUT),
        .EVENT_IRQ(EVENT_IRQ)
    );

    // Free-running 250 MHz clock
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Closing report, the one place the run ends
    task print_verdict;
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge CLK) begin
        cycles = cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            errors = errors + 1;
            print_verdict;
        end
    end

    // Compare tasks for words, responses and pins
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask
    task chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask
    task chk_pin(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // Synchronous reset held for 20 cycles
    task do_reset;
        RST <= 1'b1;
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
    endtask

    // One write: address and data offered together, each dropped when taken
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        AWVALID <= 1'b1;
        AWADDR  <= a;
        WVALID  <= 1'b1;
        WDATA   <= d;
        BREADY  <= 1'b1;
        while (!done) begin
            @(posedge CLK);
            if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1) begin
                last_resp = BRESP;
                BREADY <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // One read, data and response taken at the edge where RVALID is seen
    task rd(input logic [11:0] a);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        ARVALID <= 1'b1;
        ARADDR  <= a;
        RREADY  <= 1'b1;
        while (!done) begin
            @(posedge CLK);
            if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) begin
                last_data = RDATA;
                last_resp = RRESP;
                RREADY <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // Read and compare against an expected word
    task rd_exp(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk_word(last_data, exp);
    endtask

    // Let the registered pins settle, then compare them
    task pins(input logic irq, input logic rst);
        repeat (2) @(posedge CLK);
        #1;
        chk_pin(INTERRUPT_OUTPUT, irq);
        chk_pin(RESET_OUTPUT, rst);
    endtask

    // Wait a bounded time for a pin to reach a level (sel 1 = reset pin)
    task wait_pin(input logic sel, input logic val, input int lim);
        int n;
        n = 0;
        while (((sel ? RESET_OUTPUT : INTERRUPT_OUTPUT) !== val) && n < lim) begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk_pin(sel ? RESET_OUTPUT : INTERRUPT_OUTPUT, val);
    endtask

    // Main sequence
    initial begin
        errors = 0;
        checks_done = 0;
        cycles = 0;
        RST = 1'b1;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
        AWADDR = 12'h000;
        ARADDR = 12'h000;
        WDATA = 32'h00000000;
        WSTRB = 4'hF;
        do_reset;
        // Reset values of the register bank
        rd_exp(wdt_pkg::LOAD_OFS, 32'h0FFFFFFF);
        rd_exp(wdt_pkg::COUNT_OFS, 32'h0FFFFFFF);
        rd_exp(wdt_pkg::CTRL_OFS, 32'h00000000);
        rd_exp(wdt_pkg::RIS_OFS, 32'h00000000);
        rd_exp(wdt_pkg::KEY_OFS, 32'h00000000);
        rd_exp(wdt_pkg::TCTL_OFS, 32'h00000000);
        rd_exp(wdt_pkg::TOUT_OFS, 32'h00000000);
        // Unmapped place refused on write and read
        wr(12'h100, 32'h12345678);
        chk_resp(last_resp, wdt_pkg::RESP_SLVERR);
        rd_exp(12'h100, 32'h00000000);
        chk_resp(last_resp, wdt_pkg::RESP_SLVERR);
        // Reload write restarts the idle count at once, count itself is read-only
        wr(wdt_pkg::LOAD_OFS, 32'h00000014);
        chk_resp(last_resp, wdt_pkg::RESP_OKAY);
        rd_exp(wdt_pkg::COUNT_OFS, 32'h00000014);
        chk_resp(last_resp, wdt_pkg::RESP_OKAY);
        wr(wdt_pkg::COUNT_OFS, 32'h00000007);
        rd_exp(wdt_pkg::COUNT_OFS, 32'h00000014);
        // Timeout raises raw and masked status and the pin
        wr(wdt_pkg::CTRL_OFS, 32'h00000001);
        wait_pin(1'b0, 1'b1, 60);
        rd_exp(wdt_pkg::RIS_OFS, 32'h00000001);
        rd_exp(wdt_pkg::MIS_OFS, 32'h00000001);
        // Masking with the enable bit clears only the masked view
        wr(wdt_pkg::CTRL_OFS, 32'h00000000);
        rd_exp(wdt_pkg::MIS_OFS, 32'h00000000);
        rd_exp(wdt_pkg::RIS_OFS, 32'h00000001);
        pins(1'b0, 1'b0);
        // Clear write drops raw status and reloads the count
        wr(wdt_pkg::ICLR_OFS, 32'hDEADBEEF);
        rd_exp(wdt_pkg::RIS_OFS, 32'h00000000);
        rd_exp(wdt_pkg::COUNT_OFS, 32'h00000014);
        // Without reset enable, later zeros only reload
        wr(wdt_pkg::CTRL_OFS, 32'h00000001);
        wait_pin(1'b0, 1'b1, 60);
        repeat (100) @(posedge CLK);
        pins(1'b1, 1'b0);
        // Event interrupt raised, masked and cleared
        wr(wdt_pkg::EVMSK_OFS, 32'h00000001);
        repeat (2) @(posedge CLK);
        chk_pin(EVENT_IRQ, 1'b1);
        wr(wdt_pkg::EVMSK_OFS, 32'h00000000);
        repeat (2) @(posedge CLK);
        chk_pin(EVENT_IRQ, 1'b0);
        wr(wdt_pkg::EVST_OFS, 32'h00000001);
        wr(wdt_pkg::EVMSK_OFS, 32'h00000001);
        repeat (2) @(posedge CLK);
        chk_pin(EVENT_IRQ, 1'b0);
        // Uncleared interrupt with reset enabled: reset request, frozen count
        wr(wdt_pkg::CTRL_OFS, 32'h00000003);
        wait_pin(1'b1, 1'b1, 60);
        rd_exp(wdt_pkg::COUNT_OFS, 32'h00000000);
        repeat (30) @(posedge CLK);
        rd_exp(wdt_pkg::COUNT_OFS, 32'h00000000);
        // Dropping the reset enable drops the reset pin, interrupt stays pending
        wr(wdt_pkg::CTRL_OFS, 32'h00000001);
        pins(1'b1, 1'b0);
        do_reset;
        pins(1'b0, 1'b0);
        // Write lock and key
        wr(wdt_pkg::KEY_OFS, 32'h00000000);
        rd_exp(wdt_pkg::KEY_OFS, 32'h00000001);
        wr(wdt_pkg::LOAD_OFS, 32'h00000005);
        rd_exp(wdt_pkg::LOAD_OFS, 32'h0FFFFFFF);
        wr(wdt_pkg::CTRL_OFS, 32'h00000001);
        rd_exp(wdt_pkg::CTRL_OFS, 32'h00000000);
        rd_exp(wdt_pkg::COUNT_OFS, 32'h0FFFFFFF);
        wr(wdt_pkg::KEY_OFS, wdt_pkg::UNLOCK_KEY);
        rd_exp(wdt_pkg::KEY_OFS, 32'h00000000);
        wr(wdt_pkg::LOAD_OFS, 32'h00000005);
        rd_exp(wdt_pkg::LOAD_OFS, 32'h00000005);
        // Integration test mode drives both pins from the test register
        wr(wdt_pkg::TOUT_OFS, 32'h00000002);
        pins(1'b0, 1'b0);
        wr(wdt_pkg::TCTL_OFS, 32'h00000001);
        rd_exp(wdt_pkg::TCTL_OFS, 32'h00000001);
        pins(1'b1, 1'b0);
        wr(wdt_pkg::TOUT_OFS, 32'h00000001);
        pins(1'b0, 1'b1);
        wr(wdt_pkg::TCTL_OFS, 32'h00000000);
        pins(1'b0, 1'b0);
        print_verdict;
    end
endmodule // tb_top
